/* src/pidsr_pkg.sv */
package pidsr_pkg;
	// ==========================================================
	// value formats
	// percentages in tenths (0..1000 = 0.0..100.0 %), gains in thousandths
	localparam int PCT_W = 11;
	localparam int GAIN_W = 13;
	localparam logic [10:0] PCT_FULL = 11'h3e8;
	localparam logic [12:0] KP_MAX = 13'h1f3f;
	localparam logic [12:0] KI_MAX = 13'h1f3f;
	localparam logic [12:0] KD_MAX = 13'h0dab;
	localparam logic [12:0] KP_RESET = 13'h03e8;
	localparam logic [12:0] KI_RESET = 13'h002b;
	localparam logic [12:0] KD_RESET = 13'h0000;
	// ramp time in tenths of a second
	localparam logic [13:0] RAMP_MAX = 14'h2706;
	localparam logic [13:0] RAMP_RESET = 14'h001e;
	localparam logic [1:0] FB_SEL_RESET = 2'h1;
	localparam logic SPECIAL_RESET = 1'b0;
	// ==========================================================
	// forced parameter codes
	localparam logic [7:0] DISP_ONE_PID = 8'h0a;
	localparam logic [7:0] DISP_TWO_PID = 8'h09;
	localparam logic [7:0] DISP_THREE_PID = 8'h02;
	localparam logic [7:0] DIR_ALWAYS_FWD = 8'h00;
	localparam logic [7:0] JOG_DISABLED = 8'h00;
	localparam logic [7:0] AIN_FUNC_PV = 8'h03;
	localparam logic [7:0] DIN_FUNC_MANAUTO = 8'h16;
	// ==========================================================
	// timing
	localparam int CLK_HZ = 200_000_000;
	localparam int TICK_HZ = 1000;
	localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
	// ramp time of 1 s covers 0..100 % in 1000 ticks -> step per tick = 1000 / (ramp*100), at most one unit
	localparam int TICKS_PER_TENTH_S = TICK_HZ / 10;
	typedef enum logic [1:0] {
		PIDSR_RUN = 2'b00,
		PIDSR_SLEEP = 2'b01
	} pidsr_state_e;
endpackage : pidsr_pkg

/* src/pidsr_ramp.sv */
`timescale 1ns/1ps
module pidsr_ramp #(
	parameter int PCT_W = 11
) (
	input wire logic CLK, // clock
	input wire logic RST, // sync reset
	input wire logic tick, // control tick
	input wire logic [13:0] ramp_time, // tenths of a second
	input wire logic [PCT_W-1:0] target, // requested setpoint
	output logic [PCT_W-1:0] value // ramped setpoint
);
	// ==========================================================
	// rate accumulator: each tick adds full scale, a unit step is taken
	// every ramp_time*TICKS_PER_TENTH_S/1000 ticks (fractional by accumulator)
	logic [31:0] acc_ff;
	logic [31:0] period;
	logic step;
	logic [PCT_W-1:0] value_ff;
	initial begin
		if (PCT_W < 11) $error("pidsr_ramp: PCT_W too small");
	end
	assign period = 32'(ramp_time) * 32'(pidsr_pkg::TICKS_PER_TENTH_S);
	assign step = (ramp_time == 14'h0000) || (acc_ff + 32'(pidsr_pkg::PCT_FULL) >= period);
	always_ff @(posedge CLK) begin
		if (RST) begin
			acc_ff <= 32'h0;
		end else if (tick) begin
			if (ramp_time == 14'h0000) acc_ff <= 32'h0;
			else if (step) acc_ff <= acc_ff + 32'(pidsr_pkg::PCT_FULL) - period;
			else acc_ff <= acc_ff + 32'(pidsr_pkg::PCT_FULL);
		end
	end
	// zero ramp time jumps straight to target
	always_ff @(posedge CLK) begin
		if (RST) begin
			value_ff <= '0;
		end else if (tick && step) begin
			if (ramp_time == 14'h0000) value_ff <= target;
			else if (value_ff < target) value_ff <= value_ff + 1'b1;
			else if (value_ff > target) value_ff <= value_ff - 1'b1;
		end
	end
	assign value = value_ff;
endmodule : pidsr_ramp

/* src/pidsr_top.sv */
`timescale 1ns/1ps
module pidsr_top #(
	parameter int TICK_CYCLES = pidsr_pkg::TICK_CYCLES
) (
	input wire logic CLK, // 200 MHz clock
	input wire logic RST, // sync reset, active high
	input wire logic CFG_ALLOWED, // configuration permitted (drive stopped)
	input wire logic SPECIAL_FUNCTION_SELECT_WR, // write strobe
	input wire logic SPECIAL_FUNCTION_SELECT_IN, // 0 none, 1 regulator
	input wire logic FEEDBACK_INPUT_SELECT_WR, // write strobe
	input wire logic [1:0] FEEDBACK_INPUT_SELECT_IN, // 0..3 = analog in one..four
	input wire logic GAINS_WR, // write strobe for gains/ramp/action
	input wire logic [12:0] PROPORTIONAL_GAIN_IN, // thousandths
	input wire logic [12:0] INTEGRAL_GAIN_IN, // thousandths
	input wire logic [12:0] DIFFERENTIAL_GAIN_IN, // thousandths
	input wire logic [13:0] SETPOINT_RAMP_TIME_IN, // tenths of s
	input wire logic ACTION_TYPE_SELECT_IN, // 0 direct, 1 reverse
	input wire logic [10:0] ANALOG_INPUT_ONE, // tenths of %
	input wire logic [10:0] ANALOG_INPUT_TWO, // tenths of %
	input wire logic [10:0] ANALOG_INPUT_THREE, // tenths of %
	input wire logic [10:0] ANALOG_INPUT_FOUR, // tenths of %
	input wire logic [10:0] SETPOINT_REQ, // requested setpoint, tenths of %
	input wire logic AUTO_MODE, // automatic regulator mode
	input wire logic [10:0] MANUAL_SPEED_REF, // speed ref in manual, tenths of %
	input wire logic ZERO_SPEED_DISABLE_ENABLE, // 1 = on
	input wire logic ZERO_SPEED_DISABLE_COND, // general zero-speed disable condition met
	input wire logic ZERO_SPEED_EXIT_CONDITION, // zero-speed exit condition met
	input wire logic [10:0] WAKE_UP_BAND, // tenths of %
	input wire logic [10:0] MIN_SPEED_LIMIT, // tenths of %
	input wire logic [10:0] MAX_SPEED_LIMIT, // tenths of %
	input wire logic LOCAL_REMOTE_SEL, // 0 local, 1 remote
	input wire logic LOCAL_RUNSTOP_CMD, // run from local source
	input wire logic REMOTE_RUNSTOP_CMD, // run from remote source
	input wire logic REMOTE_ENABLE_CMD, // enable from remote source
	output logic SPECIAL_FUNCTION_SELECT, // current selector
	output logic [1:0] FEEDBACK_INPUT_SELECT, // current feedback select
	output logic [12:0] PROPORTIONAL_GAIN, // current gain
	output logic [12:0] INTEGRAL_GAIN, // current gain
	output logic [12:0] DIFFERENTIAL_GAIN, // current gain
	output logic [13:0] SETPOINT_RAMP_TIME, // current ramp time
	output logic ACTION_TYPE_SELECT, // current action
	output logic [10:0] PROCESS_VARIABLE_PCT, // read-only PV
	output logic [10:0] SETPOINT_VALUE_PCT, // read-only setpoint
	output logic [10:0] SPEED_REF, // speed reference out
	output logic SLEEPING, // sleep mode active
	output logic RUN_CMD, // resolved run command
	output logic FORCE_PULSE, // one-cycle: forced values to be written
	output logic [7:0] DISPLAY_READING_ONE_SEL, // forced value
	output logic [7:0] DISPLAY_READING_TWO_SEL, // forced value
	output logic [7:0] DISPLAY_READING_THREE_SEL, // forced value
	output logic [7:0] LOCAL_DIRECTION_SEL, // forced value
	output logic [7:0] LOCAL_JOG_SEL, // forced value
	output logic [7:0] REMOTE_DIRECTION_SEL, // forced value
	output logic [7:0] REMOTE_JOG_SEL, // forced value
	output logic [7:0] ANALOG_IN_TWO_FUNCTION, // forced value
	output logic [7:0] DIGITAL_IN_THREE_FUNCTION, // forced value
	output logic INCH_RUN_ALLOWED, // jog function active
	output logic DIRECTION_REVERSAL_ALLOWED // direction reversal active
);
	initial begin
		if (TICK_CYCLES < 2) $error("pidsr_top: TICK_CYCLES too small");
	end
	// ==========================================================
	// configuration registers
	logic special_ff, action_ff, force_ff;
	logic [1:0] fb_sel_ff;
	logic [12:0] kp_ff, ki_ff, kd_ff;
	logic [13:0] ramp_ff;
	always_ff @(posedge CLK) begin
		if (RST) special_ff <= pidsr_pkg::SPECIAL_RESET;
		else if (SPECIAL_FUNCTION_SELECT_WR && CFG_ALLOWED) special_ff <= SPECIAL_FUNCTION_SELECT_IN;
	end
	// forced writes happen on the 0 -> 1 change only, so software may later override
	always_ff @(posedge CLK) begin
		if (RST) force_ff <= 1'b0;
		else force_ff <= SPECIAL_FUNCTION_SELECT_WR && CFG_ALLOWED && SPECIAL_FUNCTION_SELECT_IN && !special_ff;
	end
	always_ff @(posedge CLK) begin
		if (RST) fb_sel_ff <= pidsr_pkg::FB_SEL_RESET;
		else if (FEEDBACK_INPUT_SELECT_WR && CFG_ALLOWED) fb_sel_ff <= FEEDBACK_INPUT_SELECT_IN;
	end
	// out-of-range gain writes saturate at the documented maximum
	always_ff @(posedge CLK) begin
		if (RST) begin
			kp_ff <= pidsr_pkg::KP_RESET;
			ki_ff <= pidsr_pkg::KI_RESET;
			kd_ff <= pidsr_pkg::KD_RESET;
			ramp_ff <= pidsr_pkg::RAMP_RESET;
			action_ff <= 1'b0;
		end else if (GAINS_WR) begin
			kp_ff <= (PROPORTIONAL_GAIN_IN > pidsr_pkg::KP_MAX) ? pidsr_pkg::KP_MAX : PROPORTIONAL_GAIN_IN;
			ki_ff <= (INTEGRAL_GAIN_IN > pidsr_pkg::KI_MAX) ? pidsr_pkg::KI_MAX : INTEGRAL_GAIN_IN;
			kd_ff <= (DIFFERENTIAL_GAIN_IN > pidsr_pkg::KD_MAX) ? pidsr_pkg::KD_MAX : DIFFERENTIAL_GAIN_IN;
			ramp_ff <= (SETPOINT_RAMP_TIME_IN > pidsr_pkg::RAMP_MAX) ? pidsr_pkg::RAMP_MAX : SETPOINT_RAMP_TIME_IN;
			action_ff <= ACTION_TYPE_SELECT_IN;
		end
	end
	// ==========================================================
	// control tick
	logic [31:0] tick_cnt_ff;
	logic tick;
	assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));
	always_ff @(posedge CLK) begin
		if (RST || tick) tick_cnt_ff <= 32'h0;
		else tick_cnt_ff <= tick_cnt_ff + 32'h1;
	end
	// ==========================================================
	// feedback and setpoint
	logic [10:0] pv_ff, sp_ramped, sp_clip;
	// an over-range level reads as full scale, so the readback never passes 100 %
	function automatic logic [10:0] pct_clamp(input logic [10:0] v);
		return (v > pidsr_pkg::PCT_FULL) ? pidsr_pkg::PCT_FULL : v;
	endfunction : pct_clamp
	always_ff @(posedge CLK) begin
		if (RST) pv_ff <= '0;
		else begin
			case (fb_sel_ff)
				2'h0: pv_ff <= pct_clamp(ANALOG_INPUT_ONE);
				2'h1: pv_ff <= pct_clamp(ANALOG_INPUT_TWO);
				2'h2: pv_ff <= pct_clamp(ANALOG_INPUT_THREE);
				default: pv_ff <= pct_clamp(ANALOG_INPUT_FOUR);
			endcase
		end
	end
	assign sp_clip = pct_clamp(SETPOINT_REQ);
	pidsr_ramp #(.PCT_W(pidsr_pkg::PCT_W)) u_ramp (
		.CLK(CLK),
		.RST(RST),
		.tick(tick),
		.ramp_time(ramp_ff),
		.target(sp_clip),
		.value(sp_ramped)
	);
	assign PROCESS_VARIABLE_PCT = pv_ff;
	assign SETPOINT_VALUE_PCT = sp_ramped;
	// ==========================================================
	// regulator
	logic signed [12:0] err, err_prev_ff;
	logic signed [31:0] integ_ff, sum, nxt_integ;
	logic [10:0] speed_ff;
	logic signed [31:0] lo, hi;
	assign err = action_ff ? (13'(PROCESS_VARIABLE_PCT) - 13'(sp_ramped))
		: (13'(sp_ramped) - 13'(PROCESS_VARIABLE_PCT));
	assign lo = 32'(MIN_SPEED_LIMIT) * 32'sd1000;
	assign hi = 32'(MAX_SPEED_LIMIT) * 32'sd1000;
	// integrator is clamped to the output span to stop wind-up
	assign nxt_integ = (integ_ff + 32'(err) * 32'($signed({1'b0, ki_ff})) > hi) ? hi
		: (integ_ff + 32'(err) * 32'($signed({1'b0, ki_ff})) < lo) ? lo
		: integ_ff + 32'(err) * 32'($signed({1'b0, ki_ff}));
	assign sum = 32'(err) * 32'($signed({1'b0, kp_ff})) + nxt_integ
		+ 32'(err - err_prev_ff) * 32'($signed({1'b0, kd_ff}));
	logic sleep_ff;
	always_ff @(posedge CLK) begin
		if (RST) begin
			integ_ff <= '0;
			err_prev_ff <= '0;
			speed_ff <= '0;
		end else if (tick) begin
			if (!special_ff || !AUTO_MODE || sleep_ff) begin
				// bumpless: integrator tracks the current output
				integ_ff <= 32'(speed_ff) * 32'sd1000;
				err_prev_ff <= err;
				speed_ff <= MANUAL_SPEED_REF;
			end else begin
				integ_ff <= nxt_integ;
				err_prev_ff <= err;
				if (sum > hi) speed_ff <= MAX_SPEED_LIMIT;
				else if (sum < lo) speed_ff <= MIN_SPEED_LIMIT;
				else speed_ff <= 11'(sum / 32'sd1000);
			end
		end
	end
	// ==========================================================
	// sleep mode
	always_ff @(posedge CLK) begin
		if (RST || !special_ff || !ZERO_SPEED_DISABLE_ENABLE) sleep_ff <= 1'b0;
		else if (!sleep_ff && ZERO_SPEED_DISABLE_COND) sleep_ff <= 1'b1;
		else if (sleep_ff && ZERO_SPEED_EXIT_CONDITION
			&& (!AUTO_MODE || (err > $signed({2'b00, WAKE_UP_BAND})))) sleep_ff <= 1'b0;
	end
	assign SLEEPING = sleep_ff;
	assign SPEED_REF = sleep_ff ? 11'h000 : speed_ff;
	// ==========================================================
	// forced parameters and command routing
	assign FORCE_PULSE = force_ff;
	assign DISPLAY_READING_ONE_SEL = pidsr_pkg::DISP_ONE_PID;
	assign DISPLAY_READING_TWO_SEL = pidsr_pkg::DISP_TWO_PID;
	assign DISPLAY_READING_THREE_SEL = pidsr_pkg::DISP_THREE_PID;
	assign LOCAL_DIRECTION_SEL = pidsr_pkg::DIR_ALWAYS_FWD;
	assign LOCAL_JOG_SEL = pidsr_pkg::JOG_DISABLED;
	assign REMOTE_DIRECTION_SEL = pidsr_pkg::DIR_ALWAYS_FWD;
	assign REMOTE_JOG_SEL = pidsr_pkg::JOG_DISABLED;
	assign ANALOG_IN_TWO_FUNCTION = pidsr_pkg::AIN_FUNC_PV;
	assign DIGITAL_IN_THREE_FUNCTION = pidsr_pkg::DIN_FUNC_MANAUTO;
	assign INCH_RUN_ALLOWED = !special_ff;
	assign DIRECTION_REVERSAL_ALLOWED = !special_ff;
	assign RUN_CMD = LOCAL_REMOTE_SEL ? (REMOTE_ENABLE_CMD && REMOTE_RUNSTOP_CMD) : LOCAL_RUNSTOP_CMD;
	assign SPECIAL_FUNCTION_SELECT = special_ff;
	assign FEEDBACK_INPUT_SELECT = fb_sel_ff;
	assign PROPORTIONAL_GAIN = kp_ff;
	assign INTEGRAL_GAIN = ki_ff;
	assign DIFFERENTIAL_GAIN = kd_ff;
	assign SETPOINT_RAMP_TIME = ramp_ff;
	assign ACTION_TYPE_SELECT = action_ff;
endmodule : pidsr_top

/* test/pidsr_xducer.sv */
`timescale 1ns/1ps
// ==========================================================
// transducer model
// the input not in use carries a distinct level so that a wrong mux choice shows
module pidsr_xducer (
	input wire logic [1:0] fb, // feedback input in use
	input wire logic [10:0] pv, // process level
	output logic [10:0] ain [4] // analog inputs one..four
);
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			ain[i] = (i == int'(fb)) ? pv : pv ^ 11'h2aa;
		end
	end
endmodule : pidsr_xducer

/* test/pidsr_props.sv */
`timescale 1ns/1ps
module pidsr_props (
	input wire logic CLK, // clock
	input wire logic RST, // reset
	input wire logic CFG_ALLOWED, // in
	input wire logic SPECIAL_FUNCTION_SELECT_WR, // in
	input wire logic SPECIAL_FUNCTION_SELECT_IN, // in
	input wire logic FEEDBACK_INPUT_SELECT_WR, // in
	input wire logic [1:0] FEEDBACK_INPUT_SELECT_IN, // in
	input wire logic ZERO_SPEED_DISABLE_ENABLE, // in
	input wire logic ZERO_SPEED_DISABLE_COND, // in
	input wire logic ZERO_SPEED_EXIT_CONDITION, // in
	input wire logic SPECIAL_FUNCTION_SELECT, // out
	input wire logic [1:0] FEEDBACK_INPUT_SELECT, // out
	input wire logic FORCE_PULSE, // out
	input wire logic [7:0] DISPLAY_READING_ONE_SEL, // out
	input wire logic [7:0] LOCAL_JOG_SEL, // out
	input wire logic [7:0] ANALOG_IN_TWO_FUNCTION, // out
	input wire logic [7:0] DIGITAL_IN_THREE_FUNCTION, // out
	input wire logic INCH_RUN_ALLOWED, // out
	input wire logic [10:0] PROCESS_VARIABLE_PCT, // out
	input wire logic [10:0] SETPOINT_VALUE_PCT, // out
	input wire logic SLEEPING, // out
	input wire logic AUTO_MODE, // in
	input wire logic [10:0] WAKE_UP_BAND, // in
	input wire logic ACTION_TYPE_SELECT // out
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	// ==========================================================
	// configuration
	property p_sel_hold;
		!(SPECIAL_FUNCTION_SELECT_WR && CFG_ALLOWED) |=> $stable(SPECIAL_FUNCTION_SELECT);
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("selector moved without write");
	property p_sel_load;
		SPECIAL_FUNCTION_SELECT_WR && CFG_ALLOWED |=> SPECIAL_FUNCTION_SELECT == $past(SPECIAL_FUNCTION_SELECT_IN);
	endproperty
	a_sel_load: assert property (p_sel_load) else $error("selector write lost");
	property p_fb_hold;
		!(FEEDBACK_INPUT_SELECT_WR && CFG_ALLOWED) |=> $stable(FEEDBACK_INPUT_SELECT);
	endproperty
	a_fb_hold: assert property (p_fb_hold) else $error("feedback select moved without write");
	property p_fb_load;
		FEEDBACK_INPUT_SELECT_WR && CFG_ALLOWED |=> FEEDBACK_INPUT_SELECT == $past(FEEDBACK_INPUT_SELECT_IN);
	endproperty
	a_fb_load: assert property (p_fb_load) else $error("feedback select write lost");
	property p_force;
		$rose(SPECIAL_FUNCTION_SELECT) |-> FORCE_PULSE && DISPLAY_READING_ONE_SEL == 8'h0a
			&& LOCAL_JOG_SEL == 8'h00 && ANALOG_IN_TWO_FUNCTION == 8'h03 && DIGITAL_IN_THREE_FUNCTION == 8'h16;
	endproperty
	a_force: assert property (p_force) else $error("forced values missing on enable");
	// a stuck or stray pulse would overwrite settings that software changed later
	property p_force_once;
		FORCE_PULSE |-> $rose(SPECIAL_FUNCTION_SELECT);
	endproperty
	a_force_once: assert property (p_force_once) else $error("force pulse without enable edge");
	property p_inch; INCH_RUN_ALLOWED != SPECIAL_FUNCTION_SELECT; endproperty
	a_inch: assert property (p_inch) else $error("inch run active with regulator");
	property p_range; PROCESS_VARIABLE_PCT <= 11'h3e8 && SETPOINT_VALUE_PCT <= 11'h3e8; endproperty
	a_range: assert property (p_range) else $error("percentage above full scale");
	// ==========================================================
	// sleep
	property p_sleep_in;
		$rose(SLEEPING) |-> $past(ZERO_SPEED_DISABLE_ENABLE && ZERO_SPEED_DISABLE_COND && SPECIAL_FUNCTION_SELECT);
	endproperty
	a_sleep_in: assert property (p_sleep_in) else $error("sleep entered without cause");
	property p_wake;
		$fell(SLEEPING) && $past(ZERO_SPEED_DISABLE_ENABLE && SPECIAL_FUNCTION_SELECT)
			|-> $past(ZERO_SPEED_EXIT_CONDITION);
	endproperty
	a_wake: assert property (p_wake) else $error("woke without exit condition");
	// direct action only: there the error is setpoint minus process variable
	property p_wake_band;
		$fell(SLEEPING) && $past(ZERO_SPEED_DISABLE_ENABLE && SPECIAL_FUNCTION_SELECT && AUTO_MODE && !ACTION_TYPE_SELECT)
			|-> $past(int'(SETPOINT_VALUE_PCT) - int'(PROCESS_VARIABLE_PCT) > int'(WAKE_UP_BAND));
	endproperty
	a_wake_band: assert property (p_wake_band) else $error("woke inside the wake-up band");
endmodule : pidsr_props

/* test/pidsr_top_tb_top.sv */
`timescale 1ns/1ps
module pidsr_top_tb_top;
	logic CLK, RST, CFG_ALLOWED, SPECIAL_FUNCTION_SELECT_WR, SPECIAL_FUNCTION_SELECT_IN, FEEDBACK_INPUT_SELECT_WR;
	logic GAINS_WR, ACTION_TYPE_SELECT_IN, AUTO_MODE, ZERO_SPEED_DISABLE_ENABLE, ZERO_SPEED_DISABLE_COND;
	logic ZERO_SPEED_EXIT_CONDITION, LOCAL_REMOTE_SEL, LOCAL_RUNSTOP_CMD, REMOTE_RUNSTOP_CMD, REMOTE_ENABLE_CMD;
	logic SPECIAL_FUNCTION_SELECT, ACTION_TYPE_SELECT, SLEEPING, RUN_CMD, FORCE_PULSE;
	logic INCH_RUN_ALLOWED, DIRECTION_REVERSAL_ALLOWED;
	logic [1:0] FEEDBACK_INPUT_SELECT_IN, FEEDBACK_INPUT_SELECT;
	logic [12:0] PROPORTIONAL_GAIN_IN, INTEGRAL_GAIN_IN, DIFFERENTIAL_GAIN_IN;
	logic [12:0] PROPORTIONAL_GAIN, INTEGRAL_GAIN, DIFFERENTIAL_GAIN;
	logic [13:0] SETPOINT_RAMP_TIME_IN, SETPOINT_RAMP_TIME;
	logic [10:0] ANALOG_INPUT_ONE, ANALOG_INPUT_TWO, ANALOG_INPUT_THREE, ANALOG_INPUT_FOUR, SETPOINT_REQ;
	logic [10:0] MANUAL_SPEED_REF, WAKE_UP_BAND, MIN_SPEED_LIMIT, MAX_SPEED_LIMIT, pv;
	logic [10:0] PROCESS_VARIABLE_PCT, SETPOINT_VALUE_PCT, SPEED_REF;
	logic [7:0] DISPLAY_READING_ONE_SEL, DISPLAY_READING_TWO_SEL, DISPLAY_READING_THREE_SEL, LOCAL_DIRECTION_SEL;
	logic [7:0] LOCAL_JOG_SEL, REMOTE_DIRECTION_SEL, REMOTE_JOG_SEL, ANALOG_IN_TWO_FUNCTION, DIGITAL_IN_THREE_FUNCTION;
	logic [10:0] ain [4];
	int mismatches = 0;
	int checks_done = 0;
	// short tick keeps the regulator waits to a few hundred cycles
	pidsr_top #(.TICK_CYCLES(10)) dut_u (.*);
	pidsr_xducer xd_u (.fb(FEEDBACK_INPUT_SELECT), .pv(pv), .ain(ain));
	assign {ANALOG_INPUT_ONE, ANALOG_INPUT_TWO, ANALOG_INPUT_THREE, ANALOG_INPUT_FOUR} = {ain[0], ain[1], ain[2], ain[3]};
	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end
	// ==========================================================
	// tasks
	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop
	// k: 0 selector, 1 feedback select, 2 gains
	task automatic wr(input int k, input logic [1:0] d);
		// a free edge first, so back-to-back calls never drop and raise a strobe in one step
		@(negedge CLK);
		SPECIAL_FUNCTION_SELECT_IN = d[0];
		FEEDBACK_INPUT_SELECT_IN = d;
		{SPECIAL_FUNCTION_SELECT_WR, FEEDBACK_INPUT_SELECT_WR, GAINS_WR} = {k == 0, k == 1, k == 2};
		@(negedge CLK);
		{SPECIAL_FUNCTION_SELECT_WR, FEEDBACK_INPUT_SELECT_WR, GAINS_WR} = 3'h0;
	endtask : wr
	task automatic wait_sleep(input logic v);
		int n;
		n = 0;
		while (SLEEPING !== v && n < 500) begin
			@(negedge CLK);
			n++;
		end
		chk("sleeping", {47'h0, v}, {47'h0, SLEEPING});
		if (SLEEPING !== v) report_and_stop();
	endtask : wait_sleep
	// ==========================================================
	// main sequence
	initial begin
		{CFG_ALLOWED, SPECIAL_FUNCTION_SELECT_WR, SPECIAL_FUNCTION_SELECT_IN, FEEDBACK_INPUT_SELECT_WR, GAINS_WR} = 5'h0;
		{ACTION_TYPE_SELECT_IN, AUTO_MODE, ZERO_SPEED_DISABLE_ENABLE, ZERO_SPEED_DISABLE_COND} = 4'h0;
		{ZERO_SPEED_EXIT_CONDITION, LOCAL_REMOTE_SEL, LOCAL_RUNSTOP_CMD, REMOTE_RUNSTOP_CMD, REMOTE_ENABLE_CMD} = 5'h0;
		{FEEDBACK_INPUT_SELECT_IN, PROPORTIONAL_GAIN_IN, INTEGRAL_GAIN_IN, DIFFERENTIAL_GAIN_IN} = 41'h0;
		{SETPOINT_RAMP_TIME_IN, SETPOINT_REQ, MANUAL_SPEED_REF} = {14'h0, 11'h320, 11'h190};
		{WAKE_UP_BAND, MIN_SPEED_LIMIT, MAX_SPEED_LIMIT, pv} = {11'h032, 11'h064, 11'h384, 11'h0c8};
		RST = 1'b1;
		repeat (3) @(negedge CLK);
		RST = 1'b0;
		chk("selector", 48'h0, SPECIAL_FUNCTION_SELECT);
		chk("fb select", 48'h1, FEEDBACK_INPUT_SELECT);
		chk("gains", {9'h0, 13'h03e8, 13'h002b, 13'h0000}, {PROPORTIONAL_GAIN, INTEGRAL_GAIN, DIFFERENTIAL_GAIN});
		chk("ramp", 48'h1e, SETPOINT_RAMP_TIME);
		$display("test reset done");
		wr(0, 2'h1);
		chk("locked selector", 48'h0, SPECIAL_FUNCTION_SELECT);
		wr(1, 2'h2);
		chk("locked fb", 48'h1, FEEDBACK_INPUT_SELECT);
		CFG_ALLOWED = 1'b1;
		// the model carries the level only on the chosen input, so a wrong pick shows in the readback
		for (int f = 0; f < 4; f++) begin
			wr(1, 2'(f));
			@(negedge CLK);
			chk("fb", 48'(f), FEEDBACK_INPUT_SELECT);
			chk("pv", 48'hc8, PROCESS_VARIABLE_PCT);
		end
		pv = 11'h7d0;
		repeat (2) @(negedge CLK);
		chk("pv clamp", 48'h3e8, PROCESS_VARIABLE_PCT);
		pv = 11'h0c8;
		wr(1, 2'h1);
		wr(0, 2'h1);
		chk("pulse", 48'h1, FORCE_PULSE);
		chk("readings", 48'h0a0902, {DISPLAY_READING_ONE_SEL, DISPLAY_READING_TWO_SEL, DISPLAY_READING_THREE_SEL});
		chk("dir jog", 48'h0, {LOCAL_DIRECTION_SEL, LOCAL_JOG_SEL, REMOTE_DIRECTION_SEL, REMOTE_JOG_SEL});
		chk("inch rev", 48'h0, {INCH_RUN_ALLOWED, DIRECTION_REVERSAL_ALLOWED});
		chk("functions", 48'h0316, {ANALOG_IN_TWO_FUNCTION, DIGITAL_IN_THREE_FUNCTION});
		$display("test config done");
		{PROPORTIONAL_GAIN_IN, INTEGRAL_GAIN_IN, DIFFERENTIAL_GAIN_IN} = {3{13'h1fff}};
		{SETPOINT_RAMP_TIME_IN, ACTION_TYPE_SELECT_IN} = {14'h3fff, 1'b1};
		wr(2, 2'h0);
		chk("gain max", {9'h0, 13'h1f3f, 13'h1f3f, 13'h0dab}, {PROPORTIONAL_GAIN, INTEGRAL_GAIN, DIFFERENTIAL_GAIN});
		chk("ramp max", 48'h2706, SETPOINT_RAMP_TIME);
		chk("action", 48'h1, ACTION_TYPE_SELECT);
		for (int i = 0; i < 16; i++) begin
			{LOCAL_REMOTE_SEL, LOCAL_RUNSTOP_CMD, REMOTE_RUNSTOP_CMD, REMOTE_ENABLE_CMD} = 4'(i);
			@(negedge CLK);
			chk("run", {47'h0, i[3] ? i[1] & i[0] : i[2]}, RUN_CMD);
		end
		$display("test limits done");
		// a large proportional gain drives the output onto a limit whatever the integrator holds
		{INTEGRAL_GAIN_IN, DIFFERENTIAL_GAIN_IN, SETPOINT_RAMP_TIME_IN, ACTION_TYPE_SELECT_IN} = 41'h0;
		wr(2, 2'h0);
		AUTO_MODE = 1'b1;
		repeat (300) @(negedge CLK);
		chk("pv", 48'hc8, PROCESS_VARIABLE_PCT);
		chk("setpoint", 48'h320, SETPOINT_VALUE_PCT);
		chk("direct", 48'h384, SPEED_REF);
		ACTION_TYPE_SELECT_IN = 1'b1;
		wr(2, 2'h0);
		repeat (300) @(negedge CLK);
		chk("reverse", 48'h64, SPEED_REF);
		{SETPOINT_RAMP_TIME_IN, SETPOINT_REQ} = {14'h1e, 11'h0};
		wr(2, 2'h0);
		repeat (300) @(negedge CLK);
		chk("ramping", 48'h1, {47'h0, SETPOINT_VALUE_PCT > 11'h300 && SETPOINT_VALUE_PCT < 11'h320});
		AUTO_MODE = 1'b0;
		repeat (100) @(negedge CLK);
		chk("manual", 48'h190, SPEED_REF);
		$display("test regulator done");
		{SETPOINT_RAMP_TIME_IN, ACTION_TYPE_SELECT_IN, SETPOINT_REQ, pv} = {15'h0, 11'h1f4, 11'h1f4};
		wr(2, 2'h0);
		AUTO_MODE = 1'b1;
		ZERO_SPEED_DISABLE_COND = 1'b1;
		repeat (100) @(negedge CLK);
		chk("sleep off", 48'h0, SLEEPING);
		ZERO_SPEED_DISABLE_ENABLE = 1'b1;
		wait_sleep(1'b1);
		{ZERO_SPEED_DISABLE_COND, ZERO_SPEED_EXIT_CONDITION} = 2'h1;
		repeat (100) @(negedge CLK);
		chk("inside band", 48'h1, SLEEPING);
		chk("sleep speed", 48'h0, SPEED_REF);
		pv = 11'h190;
		wait_sleep(1'b0);
		{pv, ZERO_SPEED_DISABLE_COND} = {11'h1f4, 1'b1};
		wait_sleep(1'b1);
		{ZERO_SPEED_DISABLE_COND, AUTO_MODE} = 2'h0;
		wait_sleep(1'b0);
		$display("test sleep done");
		report_and_stop();
	end
endmodule : pidsr_top_tb_top
bind pidsr_top pidsr_props chk_u (.*);
